// file: include/flow_tx_csr_map.svh
// Register offsets, field positions and reset values of the TX flow-control
// register slice. Included by the package and the design.
`ifndef FLOW_TX_CSR_MAP_SVH
`define FLOW_TX_CSR_MAP_SVH
`define FTX_IDX_REVISION 12'h600
`define FTX_IDX_SCRATCH 12'h601
`define FTX_IDX_VARIANT0 12'h602
`define FTX_IDX_VARIANT1 12'h603
`define FTX_IDX_VARIANT2 12'h604
`define FTX_IDX_QENABLE 12'h605
`define FTX_IDX_QREQUEST 12'h606
`define FTX_IDX_MODE2 12'h641
`define FTX_UPPER_LSB 16
`define FTX_SCRATCH_RESET 32'h00000000
`define FTX_REQUEST_RESET 32'h00000000
`endif

// file: include/flow_tx_csr_pkg.sv
// Types shared by the TX flow-control register slice.
// Assumes the offset header sits in the include path.
`include "flow_tx_csr_map.svh"
package flow_tx_csr_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [13:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } apb_rsp_t;
  typedef enum logic [1:0] {
    REQ_NONE = 2'h0,
    REQ_XOFF = 2'h2,
    REQ_INVALID = 2'h3
  } req_code_t;
endpackage

// file: verilog/flow_tx_csr.sv
// APB register slice for TX pause/PFC flow-control requests.
// Assumes one clock, an APB master and a frame generator downstream.
//
// Operation
// - Scratch word, freely read and written, resets to zero.
// - Read-only revision word and three variant identifier words.
// - One enable bit per queue, all implemented bits reset to one.
// - Enable changes any time; bits above queue count read zero.
// - Request bits act only while the queue enable is one.
// - Request bits decoded per single-bit or two-bit mode.
// - Two-bit mode honours register only where mode select picks it.
// - Single-bit: zero idle, one holds XOFF, falling edge asks XON.
// - Two-bit codes: 00 none, 10 XOFF, 11 invalid.
// - Request field resets to zero, writable any time.
// - Upper request field above bit 15 gives upper code bit.
`timescale 1ns/10ps
`default_nettype none
`include "flow_tx_csr_map.svh"
module flow_tx_csr #(
  parameter int flow_queue_count = 8,
  // Identity words: arbitrary neutral values
  parameter logic [31:0] REVISION_ID = 32'h00010000,
  parameter logic [31:0] VARIANT_0 = 32'h46434130,
  parameter logic [31:0] VARIANT_1 = 32'h46434131,
  parameter logic [31:0] VARIANT_2 = 32'h00464332
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // APB slave
  input wire flow_tx_csr_pkg::apb_req_t apb_req,
  output var flow_tx_csr_pkg::apb_rsp_t apb_rsp,
  // Mode from the surrounding core
  input wire logic two_bit_mode,
  input wire logic [flow_queue_count-1:0] mode2_reg_select,
  // To the frame generator
  output logic [flow_queue_count-1:0] xoff_request,
  output logic [flow_queue_count-1:0] xon_trigger,
  output logic [flow_queue_count-1:0] invalid_request
);
  import flow_tx_csr_pkg::*;
  // Queue count up to sixteen; the upper field starts at bit 16
  localparam int QN = flow_queue_count;

  // Whole state of the slice in one record
  typedef struct packed {
    apb_rsp_t rsp;
    logic [31:0] scratch;
    logic [QN-1:0] enable;
    logic [QN-1:0] req_low;
    logic [QN-1:0] req_high;
    logic [QN-1:0] req_low_prev;
    logic [QN-1:0] xoff;
    logic [QN-1:0] xon;
    logic [QN-1:0] invalid;
    logic [2:0] mode_sync;
    logic mode_filt;
    logic [QN-1:0] sel_s1;
    logic [QN-1:0] sel_s2;
    logic [QN-1:0] sel_s3;
    logic [QN-1:0] sel_filt;
  } state_t;

  state_t state_reg;
  state_t state_next;

  // Word index from byte address; printed offsets are word indices
  function automatic logic [11:0] word_index(input logic [13:0] a);
    word_index = a[13:2];
  endfunction

  // Queue field placed at bit 0 of a bus word, upper bits zero
  function automatic logic [31:0] pad_q(input logic [QN-1:0] v);
    logic [31:0] r;
    r = 32'h00000000;
    r[QN-1:0] = v;
    pad_q = r;
  endfunction

  // True for the seven words this slice answers
  function automatic logic is_mapped(input logic [11:0] i);
    logic hit;
    hit = 1'b0;
    case (i)
      `FTX_IDX_REVISION,
      `FTX_IDX_SCRATCH,
      `FTX_IDX_VARIANT0,
      `FTX_IDX_VARIANT1,
      `FTX_IDX_VARIANT2,
      `FTX_IDX_QENABLE,
      `FTX_IDX_QREQUEST: begin
        hit = 1'b1;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
    is_mapped = hit;
  endfunction

  // A synchronised change counts only when stages two and three agree
  function automatic logic settle(input logic held, input logic mid,
    input logic last);
    logic r;
    r = held;
    if (mid == last) begin
      r = last;
    end
    settle = r;
  endfunction

  // Two-bit request code: bit 1 asks XOFF, bit 0 flags invalid
  function automatic logic [1:0] decode_pair(input req_code_t c);
    logic [1:0] r;
    r = 2'h0;
    case (c)
      REQ_XOFF: begin
        r = 2'h2;
      end
      REQ_INVALID: begin
        r = 2'h1;
      end
      default: begin
        r = 2'h0;
      end
    endcase
    decode_pair = r;
  endfunction

  // One-to-zero transition of a request bit
  function automatic logic falling(input logic was, input logic now);
    falling = was & ~now;
  endfunction

  logic [11:0] idx;
  logic access;
  logic mode2;
  logic [QN-1:0] sel;
  logic [1:0] pair;
  req_code_t code;

  assign idx = word_index(apb_req.paddr);
  // Pready low keeps one access from being taken twice
  assign access = apb_req.psel && apb_req.penable && !state_reg.rsp.pready;
  // Only the settled copies reach the decode
  // Limitation: the mode select field arrives as pins, not a register
  assign mode2 = state_reg.mode_filt;
  assign sel = state_reg.sel_filt;

  // All next-state logic in one place; registers below
  always_comb begin
    state_next = state_reg;
    code = REQ_NONE;
    pair = 2'h0;

    // Mode inputs come from another domain: three stages, then settle
    state_next.mode_sync = {state_reg.mode_sync[1:0], two_bit_mode};
    state_next.mode_filt = settle(state_reg.mode_filt,
      state_reg.mode_sync[1], state_reg.mode_sync[2]);
    state_next.sel_s1 = mode2_reg_select;
    state_next.sel_s2 = state_reg.sel_s1;
    state_next.sel_s3 = state_reg.sel_s2;
    for (int s = 0; s < QN; s++) begin
      state_next.sel_filt[s] = settle(state_reg.sel_filt[s],
        state_reg.sel_s2[s], state_reg.sel_s3[s]);
    end

    // Answer one cycle after the access is taken; data only with ready
    state_next.rsp.pready = access;
    state_next.rsp.pslverr = 1'b0;
    state_next.rsp.prdata = 32'h00000000;
    if (access) begin
      // Unmapped words answer with an error and change nothing
      state_next.rsp.pslverr = !is_mapped(idx);
    end

    if (access && apb_req.pwrite) begin
      case (idx)
        `FTX_IDX_SCRATCH: begin
          state_next.scratch = apb_req.pwdata;
        end
        `FTX_IDX_QENABLE: begin
          state_next.enable = apb_req.pwdata[QN-1:0];
        end
        `FTX_IDX_QREQUEST: begin
          state_next.req_low = apb_req.pwdata[QN-1:0];
          state_next.req_high =
            apb_req.pwdata[`FTX_UPPER_LSB+QN-1:`FTX_UPPER_LSB];
        end
        // identity words ignore writes, no error
        `FTX_IDX_REVISION,
        `FTX_IDX_VARIANT0,
        `FTX_IDX_VARIANT1,
        `FTX_IDX_VARIANT2: begin
          state_next.scratch = state_reg.scratch;
        end
        default: begin
          state_next.scratch = state_reg.scratch;
        end
      endcase
    end

    if (access && !apb_req.pwrite) begin
      case (idx)
        `FTX_IDX_REVISION: begin
          state_next.rsp.prdata = REVISION_ID;
        end
        `FTX_IDX_VARIANT0: begin
          state_next.rsp.prdata = VARIANT_0;
        end
        `FTX_IDX_VARIANT1: begin
          state_next.rsp.prdata = VARIANT_1;
        end
        `FTX_IDX_VARIANT2: begin
          state_next.rsp.prdata = VARIANT_2;
        end
        `FTX_IDX_SCRATCH: begin
          state_next.rsp.prdata = state_reg.scratch;
        end
        `FTX_IDX_QENABLE: begin
          state_next.rsp.prdata = pad_q(state_reg.enable);
        end
        `FTX_IDX_QREQUEST: begin
          state_next.rsp.prdata =
            pad_q(state_reg.req_low) |
            (pad_q(state_reg.req_high) << `FTX_UPPER_LSB);
        end
        default: begin
          state_next.rsp.prdata = 32'h00000000;
        end
      endcase
    end

    state_next.req_low_prev = state_reg.req_low;
    // Decode runs every cycle from the registered fields
    for (int q = 0; q < QN; q++) begin
      state_next.xoff[q] = 1'b0;
      state_next.xon[q] = 1'b0;
      state_next.invalid[q] = 1'b0;
      code = req_code_t'({state_reg.req_high[q], state_reg.req_low[q]});
      pair = decode_pair(code);
      if (state_reg.enable[q]) begin
        if (!mode2) begin
          state_next.xoff[q] = state_reg.req_low[q];
          state_next.xon[q] = falling(state_reg.req_low_prev[q],
            state_reg.req_low[q]);
        end else if (sel[q]) begin
          state_next.xoff[q] = pair[1];
          state_next.invalid[q] = pair[0];
        end
      end
    end
  end

  // Reset branch loads constants only
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg.rsp.pready <= 1'b0;
      state_reg.rsp.pslverr <= 1'b0;
      state_reg.rsp.prdata <= 32'h00000000;
      state_reg.scratch <= `FTX_SCRATCH_RESET;
      state_reg.enable <= '1;
      state_reg.req_low <= QN'(`FTX_REQUEST_RESET);
      state_reg.req_high <= QN'(`FTX_REQUEST_RESET);
      state_reg.req_low_prev <= '0;
      state_reg.xoff <= '0;
      state_reg.xon <= '0;
      state_reg.invalid <= '0;
      state_reg.mode_sync <= 3'h0;
      state_reg.mode_filt <= 1'b0;
      state_reg.sel_s1 <= '0;
      state_reg.sel_s2 <= '0;
      state_reg.sel_s3 <= '0;
      state_reg.sel_filt <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output comes straight from a register
  assign apb_rsp = state_reg.rsp;
  assign xoff_request = state_reg.xoff;
  assign xon_trigger = state_reg.xon;
  assign invalid_request = state_reg.invalid;
endmodule
`default_nettype wire

// file: sim/flow_tx_csr_properties.sv
// Checker for the TX flow-control register slice.
// Bound to flow_tx_csr; sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module flow_tx_csr_properties #(parameter int flow_queue_count = 8) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Bus, mode input and outputs
  input wire flow_tx_csr_pkg::apb_req_t apb_req,
  input wire flow_tx_csr_pkg::apb_rsp_t apb_rsp,
  input wire logic two_bit_mode,
  input wire logic [flow_queue_count-1:0] xoff_request,
  input wire logic [flow_queue_count-1:0] xon_trigger,
  input wire logic [flow_queue_count-1:0] invalid_request
);
  import flow_tx_csr_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  wire logic tk = apb_req.psel && apb_req.penable && !apb_rsp.pready;
  wire logic mp = apb_req.paddr[13:2] inside {[12'h600:12'h606]};
  a_answer_next: assert property (tk |=> apb_rsp.pready)
    else $error("no answer after access");
  a_ready_pulse: assert property (apb_rsp.pready |=> !apb_rsp.pready)
    else $error("ready held too long");
  a_idle_zero: assert property (!apb_rsp.pready |-> apb_rsp.prdata == 0)
    else $error("read data outside answer");
  a_unmapped_err: assert property (tk && !mp |=> apb_rsp.pslverr)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (tk && mp |=> !apb_rsp.pslverr)
    else $error("mapped access refused");
  a_xon_single: assert property ((xon_trigger & $past(xon_trigger)) == 0)
    else $error("xon longer than a cycle");
  a_code_excl: assert property ((xoff_request & invalid_request) == 0)
    else $error("xoff and invalid together");
  a_xon_xoff: assert property ((xon_trigger & xoff_request) == 0)
    else $error("xon while xoff");
  a_two_quiet: assert property (two_bit_mode [*8] |-> xon_trigger == 0)
    else $error("xon in two-bit mode");
  cover property (apb_rsp.pslverr);
  cover property (|xon_trigger);
  cover property (|invalid_request);
endmodule
bind flow_tx_csr flow_tx_csr_properties #(
  .flow_queue_count(flow_queue_count)) flow_tx_csr_properties_i (
  .clk(clk), .reset(reset), .apb_req(apb_req), .apb_rsp(apb_rsp),
  .two_bit_mode(two_bit_mode), .xoff_request(xoff_request),
  .xon_trigger(xon_trigger), .invalid_request(invalid_request));
`default_nettype wire

// file: sim/flow_tx_csr_bench.sv
// Self-checking bench for the TX flow-control register slice.
// Drives APB and mode inputs; four queues to reach reserved bits.
`timescale 1ns/10ps
`default_nettype none
module flow_tx_csr_bench;
  import flow_tx_csr_pkg::*;
  logic clk = 0, reset = 1, mode = 0;
  logic [3:0] sel = 4'hF, seen = 4'h0;
  logic [3:0] xoff, xon, inv;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  logic [33:0] q[$], e;
  logic [31:0] rnd = 32'h4B;
  logic [31:0] rv[7] = '{32'h00010000, 0, 32'h46434130, 32'h46434131,
    32'h00464332, 32'hF, 0};
  int err_count = 0, n_tests = 0, cyc = 0;
  flow_tx_csr #(.flow_queue_count(4)) flow_tx_csr_i (.clk(clk),
    .reset(reset), .apb_req(req), .apb_rsp(rsp), .two_bit_mode(mode),
    .mode2_reg_select(sel), .xoff_request(xoff), .xon_trigger(xon),
    .invalid_request(inv));
  initial forever #2 clk = ~clk;
  task automatic chk(string n, logic [31:0] x, logic [31:0] s);
    n_tests++;
    if (x !== s) begin
      $display("Error %s exp %h got %h", n, x, s);
      err_count++;
    end
  endtask
  task automatic give_verdict();
    if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] x);
    q.push_back({w, x});
    @(posedge clk) req <= '{1'b1, 1'b0, w, {a, 2'h0}, d};
    @(posedge clk) req.penable <= 1'b1;
    do @(posedge clk); while (rsp.pready !== 1'b1);
    req <= '0;
  endtask
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Pulses are short; keep every xon seen
  always @(negedge clk) seen <= seen | xon;
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      err_count++;
      give_verdict();
    end else if (rsp.pready === 1'b1) begin
      e = q.pop_front();
      chk("pslverr", {31'h0, e[32]}, {31'h0, rsp.pslverr});
      if (!e[33]) chk("prdata", e[31:0], rsp.prdata);
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    reset <= 0;
    for (int i = 0; i < 7; i++) apb(0, 12'(i + 'h600), 0, {1'b0, rv[i]});
    rnd = lfsr(rnd);
    apb(1, 12'h601, rnd, 0);
    apb(0, 12'h601, 0, {1'b0, rnd});
    apb(1, 12'h600, rnd, 0);
    apb(0, 12'h600, 0, {1'b0, rv[0]});
    apb(1, 12'h605, 32'hFFFFFFF5, 0);
    apb(0, 12'h605, 0, 33'h5);
    apb(0, 12'h607, 0, 33'h100000000);
    apb(1, 12'h606, 32'hF, 0);
    apb(1, 12'h606, 0, 0);
    repeat (3) @(negedge clk);
    chk("xon", 4'h5, seen);
    @(posedge clk) mode <= 1'b1;
    sel <= 4'h7;
    apb(1, 12'h605, 32'hF, 0);
    apb(1, 12'h606, 32'h000E000C, 0);
    repeat (3) @(negedge clk);
    chk("xoff", 4'h2, xoff);
    chk("invalid", 4'h4, inv);
    chk("xon", 4'h5, seen);
    // Reset pulse on the reset input after a static change brings back reset values
    @(posedge clk) reset <= 1'b1;
    @(posedge clk) reset <= 1'b0;
    apb(0, 12'h601, 0, 33'h0);
    apb(0, 12'h605, 0, 33'hF);
    apb(0, 12'h606, 0, 33'h0);
    give_verdict();
  end
endmodule
`default_nettype wire
